// *** logic/cipg_top.sv ***
// Codec interrupt generation: flag registers, two interrupt controls, two pulse outputs.
// Assumes event inputs synchronous to i_clk and a one-cycle register read/write strobe.
`timescale 1ns/1ps
//
// Contract
// - ADC flag bit 6 shows gain-loop noise condition live.
// - First control bit 7 enables headset insertion events.
// - First control bit 6 enables button press events.
// - First control bit 5 enables compressor signal-power events.
// - First control bit 4 enables gain-loop noise events.
// - First control bit 3 enables short-circuit events.
// - First control bit 2 enables DAC overflow events.
// - First control bit 1 enables DC-measurement ready events.
// - First control bit 0 low: one 2 ms high pulse per event.
// - First bit 0 high: 2 ms pulses every 4 ms until 44, 45 read.
// - Second control enables same sources except DAC overflow (bit 2) for second output.
// - Second control bit 0 low: one 2 ms pulse per event.
// - Second bit 0 high: repeated pulses until 44, 45 read.
// - Sticky flags read-only, clear on read, set on recurrence.
// - Register 44 holds shorts, button, headset, compressor bits.
module cipg_top
  import cipg_pkg::*;
#(
  parameter int unsigned P_PULSE_CYC  = PULSE_CYC,
  parameter int unsigned P_PERIOD_CYC = PERIOD_CYC
) (
  input  wire logic          i_clk,
  input  wire logic          i_rst,
  input  wire cipg_evt_t     i_evt,
  input  wire cipg_reg_req_t i_reg,
  output logic [7:0]         o_reg_rdata,
  output logic               o_irq_out_first,
  output logic               o_irq_out_second
);

  cipg_top_t  s_q;
  cipg_top_t  s_d;
  cipg_evt_t  rise;
  logic       hs_change;
  logic [7:0] set_dac;
  logic [7:0] set_adc;
  logic [7:0] src;
  logic [7:0] flags_dac;
  logic [7:0] flags_adc;
  logic [7:0] live_dac;
  logic [7:0] adc_view;
  logic       rd_dac;
  logic       rd_adc;
  logic       trig1;
  logic       trig2;

  always_comb begin
    rise      = cipg_evt_t'(i_evt & ~s_q.prev);
    hs_change = i_evt.hs_present ^ s_q.prev.hs_present;
    rd_dac    = i_reg.rd && (i_reg.addr == ADDR_DAC_STICKY);
    rd_adc    = i_reg.rd && (i_reg.addr == ADDR_ADC_STICKY);

    set_dac            = 8'h00;
    set_dac[F_SHORT_L] = rise.short_left;
    set_dac[F_SHORT_R] = rise.short_right;
    set_dac[F_BTN]     = rise.button;
    set_dac[F_HS]      = hs_change;
    set_dac[F_COMP_L]  = rise.comp_left;
    set_dac[F_COMP_R]  = rise.comp_right;

    set_adc          = 8'h00;
    set_adc[F_NOISE] = rise.auto_gain_noise;
    set_adc[F_DC]    = rise.dc_ready;

    live_dac            = 8'h00;
    live_dac[F_SHORT_L] = i_evt.short_left;
    live_dac[F_SHORT_R] = i_evt.short_right;
    live_dac[F_BTN]     = i_evt.button;
    live_dac[F_HS]      = i_evt.hs_present;
    live_dac[F_COMP_L]  = i_evt.comp_left;
    live_dac[F_COMP_R]  = i_evt.comp_right;

    adc_view          = s_q.adc_rw & ADC_FLAGS_WR_MASK;
    adc_view[F_NOISE] = i_evt.auto_gain_noise;
    adc_view[F_DC]    = i_evt.dc_ready;

    src             = 8'h00;
    src[CTL_HS]     = hs_change;
    src[CTL_BTN]    = rise.button;
    src[CTL_COMP]   = rise.comp_left | rise.comp_right;
    src[CTL_NOISE]  = rise.auto_gain_noise;
    src[CTL_SHORT]  = rise.short_left | rise.short_right;
    src[CTL_OVF]    = rise.dac_overflow;
    src[CTL_DC]     = rise.dc_ready;

    trig1 = |(src & s_q.ctrl1 & SRC_MASK);
    trig2 = |(src & s_q.ctrl2 & IRQ2_WR_MASK & SRC_MASK);

    s_d      = s_q;
    s_d.prev = i_evt;

    if (i_reg.wr) begin
      unique case (i_reg.addr)
        ADDR_ADC_FLAGS: s_d.adc_rw = i_reg.wdata & ADC_FLAGS_WR_MASK;
        ADDR_IRQ1_CTRL: s_d.ctrl1  = i_reg.wdata & IRQ1_WR_MASK;
        ADDR_IRQ2_CTRL: s_d.ctrl2  = i_reg.wdata & IRQ2_WR_MASK;
        ADDR_RSVD_A:    s_d.rsvd_a = i_reg.wdata;
        ADDR_RSVD_B:    s_d.rsvd_b = i_reg.wdata;
        default:        s_d.rsvd_a = s_q.rsvd_a;
      endcase
    end

    // Read data is captured before the sticky bits clear on this edge
    if (i_reg.rd) begin
      unique case (i_reg.addr)
        ADDR_DAC_STICKY: s_d.rdata = flags_dac;
        ADDR_ADC_STICKY: s_d.rdata = flags_adc;
        ADDR_DAC_LIVE:   s_d.rdata = live_dac;
        ADDR_ADC_FLAGS:  s_d.rdata = adc_view;
        ADDR_IRQ1_CTRL:  s_d.rdata = s_q.ctrl1;
        ADDR_IRQ2_CTRL:  s_d.rdata = s_q.ctrl2;
        ADDR_RSVD_A:     s_d.rdata = s_q.rsvd_a;
        ADDR_RSVD_B:     s_d.rdata = s_q.rsvd_b;
        default:         s_d.rdata = 8'h00;
      endcase
    end

    s_d.seen1 = trig1 ? 2'b00 : (s_q.seen1 | {rd_adc, rd_dac});
    s_d.seen2 = trig2 ? 2'b00 : (s_q.seen2 | {rd_adc, rd_dac});
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      s_q <= '{prev: '0, ctrl1: CTRL_RST, ctrl2: CTRL_RST, adc_rw: ADC_FLAGS_RST,
               rsvd_a: RSVD_A_RST, rsvd_b: RSVD_B_RST, rdata: 8'h00, seen1: 2'b00, seen2: 2'b00};
    end else begin
      s_q <= s_d;
    end
  end

  cipg_sticky_flags u_flags_dac (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_set   (set_dac),
    .i_clear (rd_dac),
    .o_flags (flags_dac)
  );

  cipg_sticky_flags u_flags_adc (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_set   (set_adc),
    .i_clear (rd_adc),
    .o_flags (flags_adc)
  );

  cipg_pulse_gen #(
    .P_PULSE_CYC  (P_PULSE_CYC),
    .P_PERIOD_CYC (P_PERIOD_CYC)
  ) u_pulse_first (
    .i_clk     (i_clk),
    .i_rst     (i_rst),
    .i_trigger (trig1),
    .i_repeat  (s_q.ctrl1[CTL_REPEAT]),
    .i_served  (&s_q.seen1),
    .o_irq     (o_irq_out_first)
  );

  cipg_pulse_gen #(
    .P_PULSE_CYC  (P_PULSE_CYC),
    .P_PERIOD_CYC (P_PERIOD_CYC)
  ) u_pulse_second (
    .i_clk     (i_clk),
    .i_rst     (i_rst),
    .i_trigger (trig2),
    .i_repeat  (s_q.ctrl2[CTL_REPEAT]),
    .i_served  (&s_q.seen2),
    .o_irq     (o_irq_out_second)
  );

  assign o_reg_rdata = s_q.rdata;

endmodule // cipg_top

// *** logic/cipg_pkg.sv ***
// Shared constants and types of the codec interrupt pulse generator.
// Assumes one 20 MHz core clock and a byte-wide register port.
package cipg_pkg;

  // Register offsets
  localparam logic [7:0] ADDR_DAC_STICKY = 8'h2c;
  localparam logic [7:0] ADDR_ADC_STICKY = 8'h2d;
  localparam logic [7:0] ADDR_DAC_LIVE   = 8'h2e;
  localparam logic [7:0] ADDR_ADC_FLAGS  = 8'h2f;
  localparam logic [7:0] ADDR_IRQ1_CTRL  = 8'h30;
  localparam logic [7:0] ADDR_IRQ2_CTRL  = 8'h31;
  localparam logic [7:0] ADDR_RSVD_A     = 8'h32;
  localparam logic [7:0] ADDR_RSVD_B     = 8'h34;

  // Interrupt control fields
  localparam int CTL_HS     = 7;
  localparam int CTL_BTN    = 6;
  localparam int CTL_COMP   = 5;
  localparam int CTL_NOISE  = 4;
  localparam int CTL_SHORT  = 3;
  localparam int CTL_OVF    = 2;
  localparam int CTL_DC     = 1;
  localparam int CTL_REPEAT = 0;

  // Flag register fields
  localparam int F_SHORT_L = 7;
  localparam int F_SHORT_R = 6;
  localparam int F_BTN     = 5;
  localparam int F_HS      = 4;
  localparam int F_COMP_L  = 3;
  localparam int F_COMP_R  = 2;
  localparam int F_NOISE   = 6;
  localparam int F_DC      = 2;

  // Writable bits and reset values
  localparam logic [7:0] ADC_FLAGS_WR_MASK = 8'ha3;
  localparam logic [7:0] IRQ1_WR_MASK      = 8'hff;
  localparam logic [7:0] IRQ2_WR_MASK      = 8'hfb;
  localparam logic [7:0] SRC_MASK          = 8'hfe;
  localparam logic [7:0] CTRL_RST          = 8'h00;
  localparam logic [7:0] ADC_FLAGS_RST     = 8'h00;
  localparam logic [7:0] RSVD_A_RST        = 8'h00;
  localparam logic [7:0] RSVD_B_RST        = 8'h00;

  // Timing
  localparam int unsigned CLK_HZ      = 20_000_000;
  localparam int unsigned T_PULSE_US  = 2000;
  localparam int unsigned T_PERIOD_US = 4000;
  localparam int unsigned PULSE_CYC   = T_PULSE_US * (CLK_HZ / 1_000_000);
  localparam int unsigned PERIOD_CYC  = T_PERIOD_US * (CLK_HZ / 1_000_000);
  localparam int          CNT_W       = 17;

  typedef struct packed {
    logic short_left;
    logic short_right;
    logic button;
    logic hs_present;
    logic comp_left;
    logic comp_right;
    logic auto_gain_noise;
    logic dac_overflow;
    logic dc_ready;
  } cipg_evt_t;

  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } cipg_reg_req_t;

  typedef enum logic [1:0] {PG_IDLE, PG_HIGH, PG_LOW} cipg_pg_state_t;

  typedef struct packed {
    cipg_pg_state_t   st;
    logic [CNT_W-1:0] cnt;
    logic             irq;
  } cipg_pg_t;

  typedef struct packed {
    logic [7:0] bits;
  } cipg_sticky_t;

  typedef struct packed {
    cipg_evt_t  prev;
    logic [7:0] ctrl1;
    logic [7:0] ctrl2;
    logic [7:0] adc_rw;
    logic [7:0] rsvd_a;
    logic [7:0] rsvd_b;
    logic [7:0] rdata;
    logic [1:0] seen1;
    logic [1:0] seen2;
  } cipg_top_t;

endpackage

// *** logic/cipg_sticky_flags.sv ***
// Eight sticky flag bits, cleared by a read of their register.
// Assumes i_set carries one-cycle event pulses.
`timescale 1ns/1ps
module cipg_sticky_flags
  import cipg_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic [7:0] i_set,
  input  wire logic       i_clear,
  output logic [7:0]      o_flags
);

  cipg_sticky_t s_q;
  cipg_sticky_t s_d;
  logic [7:0]   next_bits;

  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_bit
      assign next_bits[g] = i_set[g] | (s_q.bits[g] & ~i_clear);
    end
  endgenerate

  always_comb begin
    s_d      = s_q;
    s_d.bits = next_bits;
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_flags = s_q.bits;

endmodule // cipg_sticky_flags

// *** logic/cipg_pulse_gen.sv ***
// Interrupt pulse sequencer: one pulse, or repeated pulses until serviced.
// Assumes i_trigger is a one-cycle pulse and i_served a level from the top.
`timescale 1ns/1ps
module cipg_pulse_gen
  import cipg_pkg::*;
#(
  parameter int unsigned P_PULSE_CYC  = PULSE_CYC,
  parameter int unsigned P_PERIOD_CYC = PERIOD_CYC
) (
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_trigger,
  input  wire logic i_repeat,
  input  wire logic i_served,
  output logic      o_irq
);

  cipg_pg_t s_q;
  cipg_pg_t s_d;

  always_comb begin
    s_d = s_q;
    unique case (s_q.st)
      PG_IDLE: begin
        if (i_trigger) begin
          s_d.st  = PG_HIGH;
          s_d.cnt = '0;
        end
      end
      PG_HIGH: begin
        // Events during a pulse merge into it
        if (s_q.cnt == CNT_W'(P_PULSE_CYC - 1)) begin
          if (i_repeat && !i_served) begin
            s_d.st  = PG_LOW;
            s_d.cnt = s_q.cnt + 1'b1;
          end else begin
            s_d.st = PG_IDLE;
          end
        end else begin
          s_d.cnt = s_q.cnt + 1'b1;
        end
      end
      PG_LOW: begin
        if (i_served || !i_repeat) begin
          s_d.st = PG_IDLE;
        end else if (s_q.cnt == CNT_W'(P_PERIOD_CYC - 1)) begin
          s_d.st  = PG_HIGH;
          s_d.cnt = '0;
        end else begin
          s_d.cnt = s_q.cnt + 1'b1;
        end
      end
    endcase
    s_d.irq = (s_d.st == PG_HIGH);
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      s_q <= '{st: PG_IDLE, cnt: '0, irq: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign o_irq = s_q.irq;

endmodule // cipg_pulse_gen

// *** test/cipg_properties.sv ***
// Port-level assertions for the codec interrupt pulse generator.
// Assumes binding to cipg_top; mirrors the control registers from the write strobes.
`timescale 1ns/1ps
module cipg_properties
  import cipg_pkg::*;
#(
  parameter int unsigned P_PULSE_CYC  = PULSE_CYC,
  parameter int unsigned P_PERIOD_CYC = PERIOD_CYC
) (
  input wire logic          i_clk,
  input wire logic          i_rst,
  input wire cipg_evt_t     i_evt,
  input wire cipg_reg_req_t i_reg,
  input wire logic [7:0]    o_reg_rdata,
  input wire logic          o_irq_out_first,
  input wire logic          o_irq_out_second
);
  cipg_evt_t   prev_q;
  logic [7:0]  c1_q;
  logic [7:0]  c2_q;
  logic [16:0] hi1_q;
  logic [16:0] hi2_q;
  logic [16:0] lo1_q;
  logic [16:0] lo2_q;
  logic [8:0]  r;
  logic [7:0]  src;
  logic        trig1;
  logic        trig2;
  assign r = i_evt & ~prev_q;
  // Same bit order as the control registers, bit 0 unused
  assign src = {i_evt.hs_present ^ prev_q.hs_present, r[6], r[4] | r[3], r[2], r[8] | r[7], r[1], r[0], 1'b0};
  assign trig1 = |(src & c1_q);
  assign trig2 = |(src & c2_q);
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      prev_q <= '0;
      c1_q   <= 8'h00;
      c2_q   <= 8'h00;
      hi1_q  <= '0;
      hi2_q  <= '0;
      lo1_q  <= '0;
      lo2_q  <= '0;
    end else begin
      prev_q <= i_evt;
      if (i_reg.wr && i_reg.addr == ADDR_IRQ1_CTRL) c1_q <= i_reg.wdata & IRQ1_WR_MASK;
      if (i_reg.wr && i_reg.addr == ADDR_IRQ2_CTRL) c2_q <= i_reg.wdata & IRQ2_WR_MASK;
      hi1_q <= o_irq_out_first ? hi1_q + 17'h1 : 17'h0;
      hi2_q <= o_irq_out_second ? hi2_q + 17'h1 : 17'h0;
      lo1_q <= o_irq_out_first ? 17'h0 : lo1_q + 17'h1;
      lo2_q <= o_irq_out_second ? 17'h0 : lo2_q + 17'h1;
    end
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  sequence s_idle1;
    // A train cut short by clearing repeat mode still needs one cycle to reach idle
    !o_irq_out_first && !$past(o_irq_out_first) && !c1_q[0] && !$past(c1_q[0]);
  endsequence
  sequence s_idle2;
    !o_irq_out_second && !$past(o_irq_out_second) && !c2_q[0] && !$past(c2_q[0]);
  endsequence
  sequence s_rd_adc;
    i_reg.rd && i_reg.addr == ADDR_ADC_FLAGS;
  endsequence
  property p_start1; s_idle1 ##0 trig1 |=> o_irq_out_first; endproperty
  property p_cause1; $rose(o_irq_out_first) && !c1_q[0] |-> $past(trig1); endproperty
  property p_width1; $fell(o_irq_out_first) |-> hi1_q == P_PULSE_CYC; endproperty
  property p_gap1;
    $rose(o_irq_out_first) && c1_q[0] && !$past(trig1) |-> lo1_q == P_PERIOD_CYC - P_PULSE_CYC;
  endproperty
  property p_start2; s_idle2 ##0 trig2 |=> o_irq_out_second; endproperty
  property p_cause2; $rose(o_irq_out_second) && !c2_q[0] |-> $past(trig2); endproperty
  property p_width2; $fell(o_irq_out_second) |-> hi2_q == P_PULSE_CYC; endproperty
  property p_gap2;
    $rose(o_irq_out_second) && c2_q[0] && !$past(trig2) |-> lo2_q == P_PERIOD_CYC - P_PULSE_CYC;
  endproperty
  property p_flag6;
    s_rd_adc |=> o_reg_rdata[6] == $past(i_evt.auto_gain_noise) && o_reg_rdata[2] == $past(i_evt.dc_ready);
  endproperty
  a_start1: assert property (p_start1) else $error("first output did not start on enabled event");
  a_cause1: assert property (p_cause1) else $error("first output rose without enabled event");
  a_width1: assert property (p_width1) else $error("first output pulse width wrong");
  a_gap1: assert property (p_gap1) else $error("first output repeat gap wrong");
  a_start2: assert property (p_start2) else $error("second output did not start on enabled event");
  a_cause2: assert property (p_cause2) else $error("second output rose without enabled event");
  a_width2: assert property (p_width2) else $error("second output pulse width wrong");
  a_gap2: assert property (p_gap2) else $error("second output repeat gap wrong");
  a_flag6: assert property (p_flag6) else $error("live status bits in flag read wrong");
endmodule // cipg_properties

// *** test/cipg_host_model.sv ***
// Host processor model: register port transfers and interrupt servicing.
// Assumes requests launch on the falling edge and read data lands after the taking edge.
`timescale 1ns/1ps
module cipg_host_model
  import cipg_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic [7:0] i_rdata,
  output cipg_reg_req_t   o_reg
);
  initial o_reg = '{addr: 8'h00, wr: 1'b0, rd: 1'b0, wdata: 8'h00};
  task automatic xfer(input logic [7:0] a, input logic w, input logic [7:0] d, output logic [7:0] q);
    @(negedge i_clk);
    o_reg = '{addr: a, wr: w, rd: ~w, wdata: d};
    @(negedge i_clk);
    q = i_rdata;
    // Released fields show the inverse so a stale value cannot pass for a fresh one
    o_reg = '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: ~d};
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] v;
    logic [7:0] q;
    v = d;
    if (a == ADDR_ADC_FLAGS) v = d & 8'hfc;
    if (a == ADDR_RSVD_B) v = RSVD_B_RST;
    xfer(a, 1'b1, v, q);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    xfer(a, 1'b0, 8'h00, q);
  endtask
  task automatic service();
    logic [7:0] q;
    rd(ADDR_DAC_STICKY, q);
    rd(ADDR_ADC_STICKY, q);
  endtask
endmodule // cipg_host_model

// *** test/tb.sv ***
// Self-checking bench for the codec interrupt pulse generator.
// Assumes shortened pulse timing: 8 cycles high, 16 cycle period.
`timescale 1ns/1ps
module tb
  import cipg_pkg::*;
;
  localparam int unsigned PP = 8;
  localparam int unsigned PR = 16;
  logic          clk = 1'b0;
  logic          rst = 1'b1;
  cipg_evt_t     evt = '0;
  cipg_reg_req_t req;
  logic [7:0]    rdata;
  logic          irq1;
  logic          irq2;
  int            miscompares = 0;
  int            n_compared = 0;
  int            pos [1:7] = '{0, 1, 7, 2, 4, 6, 5};
  logic [7:0]    f44 [1:7] = '{8'h00, 8'h00, 8'h40, 8'h00, 8'h08, 8'h20, 8'h10};
  logic [7:0]    f45 [1:7] = '{8'h04, 8'h00, 8'h00, 8'h40, 8'h00, 8'h00, 8'h00};
  logic [7:0]    wa [7] = '{ADDR_IRQ2_CTRL, ADDR_IRQ1_CTRL, ADDR_ADC_FLAGS, ADDR_DAC_STICKY, ADDR_RSVD_A, ADDR_RSVD_B, 8'h33};
  logic [7:0]    we [7] = '{8'hfb, 8'hff, 8'ha0, 8'h00, 8'hff, 8'h00, 8'h00};
  always #25 clk = ~clk;
  cipg_top #(.P_PULSE_CYC(PP), .P_PERIOD_CYC(PR)) cipg_top_inst (.i_clk(clk), .i_rst(rst), .i_evt(evt),
    .i_reg(req), .o_reg_rdata(rdata), .o_irq_out_first(irq1), .o_irq_out_second(irq2));
  cipg_host_model cipg_host_model_inst (.i_clk(clk), .i_rdata(rdata), .o_reg(req));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("compared=%0d mismatches=%0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic t_regs();
    logic [7:0] q;
    for (int a = 'h2c; a <= 'h34; a++) begin
      cipg_host_model_inst.rd(8'(a), q);
      chk(q, 8'h00);
    end
    for (int i = 0; i < 7; i++) begin
      cipg_host_model_inst.wr(wa[i], 8'hff);
      cipg_host_model_inst.rd(wa[i], q);
      chk(q, we[i]);
    end
    cipg_host_model_inst.wr(ADDR_IRQ1_CTRL, 8'h00);
    cipg_host_model_inst.wr(ADDR_IRQ2_CTRL, 8'h00);
  endtask
  task automatic t_src(input int b);
    logic [7:0] q;
    int n;
    // Every other source enabled: a swapped enable bit shows here
    cipg_host_model_inst.wr(ADDR_IRQ1_CTRL, 8'hfe & ~(8'h01 << b));
    cipg_host_model_inst.wr(ADDR_IRQ2_CTRL, 8'hfa & ~(8'h01 << b));
    evt = cipg_evt_t'(9'h001 << pos[b]);
    repeat (3) @(negedge clk);
    chk({6'h0, irq1, irq2}, 8'h00);
    evt = '0;
    repeat (12) @(negedge clk);
    cipg_host_model_inst.service();
    cipg_host_model_inst.wr(ADDR_IRQ1_CTRL, 8'h01 << b);
    cipg_host_model_inst.wr(ADDR_IRQ2_CTRL, 8'h01 << b);
    evt = cipg_evt_t'(9'h001 << pos[b]);
    @(negedge clk);
    chk({6'h0, irq1, irq2}, {6'h0, 1'b1, b != 2});
    n = 1;
    while (irq1 === 1'b1 && n < 40) begin
      @(negedge clk);
      if (irq1 === 1'b1) n++;
    end
    chk(8'(n), 8'(PP));
    cipg_host_model_inst.rd(ADDR_ADC_FLAGS, q);
    // Bits 7 and 5 still hold what the register test stored
    chk(q, f45[b] | 8'ha0);
    cipg_host_model_inst.rd(ADDR_DAC_LIVE, q);
    chk(q, f44[b]);
    evt = '0;
    repeat (12) @(negedge clk);
    cipg_host_model_inst.rd(ADDR_DAC_STICKY, q);
    chk(q, f44[b]);
    cipg_host_model_inst.rd(ADDR_ADC_STICKY, q);
    chk(q, f45[b]);
    cipg_host_model_inst.rd(ADDR_DAC_STICKY, q);
    chk(q, 8'h00);
  endtask
  task automatic count_high(input int cyc, output int n1, output int n2);
    n1 = 0;
    n2 = 0;
    repeat (cyc) begin
      @(negedge clk);
      if (irq1 === 1'b1) n1++;
      if (irq2 === 1'b1) n2++;
    end
  endtask
  task automatic t_repeat();
    logic [7:0] q;
    int n1;
    int n2;
    cipg_host_model_inst.wr(ADDR_IRQ1_CTRL, 8'h03);
    cipg_host_model_inst.wr(ADDR_IRQ2_CTRL, 8'h03);
    evt.dc_ready = 1'b1;
    count_high(3 * PR, n1, n2);
    chk(8'(n1), 8'(3 * PP));
    chk(8'(n2), 8'(3 * PP));
    // One flag register read alone must not stop the train
    cipg_host_model_inst.rd(ADDR_DAC_STICKY, q);
    count_high(2 * PR, n1, n2);
    chk(8'(n1), 8'(2 * PP));
    chk(8'(n2), 8'(2 * PP));
    cipg_host_model_inst.rd(ADDR_ADC_STICKY, q);
    repeat (PP + 2) @(negedge clk);
    count_high(2 * PR, n1, n2);
    chk(8'(n1), 8'h00);
    chk(8'(n2), 8'h00);
    evt = '0;
  endtask
  initial begin
    repeat (8) @(negedge clk);
    rst = 1'b0;
    t_regs();
    $display("test regs done");
    for (int b = 1; b <= 7; b++) t_src(b);
    $display("test sources done");
    t_repeat();
    $display("test repeat done");
    tally_and_finish();
  end
  initial begin
    repeat (5000) @(posedge clk);
    miscompares++;
    tally_and_finish();
  end
endmodule // tb
bind cipg_top cipg_properties #(.P_PULSE_CYC(P_PULSE_CYC), .P_PERIOD_CYC(P_PERIOD_CYC)) cipg_properties_inst (
  .i_clk(i_clk), .i_rst(i_rst), .i_evt(i_evt), .i_reg(i_reg), .o_reg_rdata(o_reg_rdata),
  .o_irq_out_first(o_irq_out_first), .o_irq_out_second(o_irq_out_second));
